// file: design/lit_move_exec.sv
// Executor for the literal and move group, driven over Avalon-MM.
// Assumes a master that holds each request until waitrequest is low.
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lit_move_exec #(
  parameter int AW = exec_pkg::MEM_AW  // Data memory address width
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             soft_reset_req
);

  exec_pkg::bus_st_t             st_q;      // Bus slave state
  exec_pkg::dec_t                dec;       // Decoded write data
  logic [exec_pkg::K8_W-1:0]     acc_q;     // Accumulator
  logic [exec_pkg::K5_W-1:0]     bank_q;    // bank_select_reg
  logic [exec_pkg::K7_W-1:0]     page_q;    // pc_high_latch
  logic [exec_pkg::K8_W-1:0]     option_q;  // Timer option register
  logic [exec_pkg::ST_W-1:0]     status_q;  // Status flags
  logic [exec_pkg::PW-1:0]       ptr0_q;    // file_select_pointer 0
  logic [exec_pkg::PW-1:0]       ptr1_q;    // file_select_pointer 1
  logic [exec_pkg::PC_W-1:0]     pc_q;      // Program counter
  logic                          rif_q;     // reset_instr_flag
  logic [AW-1:0]                 maddr_q;   // Memory peek address
  logic [exec_pkg::IW-1:0]       word;      // Instruction bits
  logic [exec_pkg::PW-1:0]       ptr_cur;   // Selected pointer
  logic [exec_pkg::PW-1:0]       eff_addr;  // Indirect address
  logic [exec_pkg::PW-1:0]       ptr_nxt;   // Pointer after access
  logic [exec_pkg::PW-1:0]       dir_addr;  // Bank plus file address
  logic                          req_wr;    // Write being answered
  logic                          exec;      // Instruction issue
  logic                          mem_we;    // Memory write strobe
  logic [AW-1:0]                 mem_wa;    // Memory write address
  logic [exec_pkg::K8_W-1:0]     mem_wd;    // Memory write data
  logic [exec_pkg::K8_W-1:0]     mem_rd;    // Memory read data
  logic [31:0]                   rd_val;    // Read mux

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  assign word     = avs_writedata[exec_pkg::IW-1:0];
  assign req_wr   = (st_q == exec_pkg::ST_WAIT) && avs_write;
  assign exec     = req_wr && (avs_address == exec_pkg::REG_INSTR);
  assign ptr_cur  = dec.sel ? ptr1_q : ptr0_q;
  assign dir_addr = {{(exec_pkg::PW-exec_pkg::K5_W-exec_pkg::K7_W){1'b0}},
                     bank_q, dec.f};

  // Decode; unknown words act as no_operation
  always_comb begin
    dec      = '0;
    dec.op   = exec_pkg::OP_UNDEF;
    dec.lit  = word[exec_pkg::K8_W-1:0];
    dec.f    = word[exec_pkg::K7_W-1:0];
    dec.mode = exec_pkg::pmode_t'(word[exec_pkg::PM_W-1:0]);
    dec.off  = word[exec_pkg::OFF_W-1:0];
    if (word == exec_pkg::ENC_NOOP) begin
      dec.op = exec_pkg::OP_NOOP;
    end else if (word == exec_pkg::ENC_SWRST) begin
      dec.op = exec_pkg::OP_SWRST;
    end else if (word == exec_pkg::ENC_OPTION) begin
      dec.op = exec_pkg::OP_OPTION;
    end else if ((word & exec_pkg::MSK_BANK) == exec_pkg::MAT_BANK) begin
      dec.op = exec_pkg::OP_BANK;
    end else if ((word & exec_pkg::MSK_PAGE) == exec_pkg::MAT_PAGE) begin
      dec.op = exec_pkg::OP_PAGE;
    end else if ((word & exec_pkg::MSK_ACC) == exec_pkg::MAT_ACC) begin
      dec.op = exec_pkg::OP_ACC;  // Don't-care bits ignored
    end else if ((word & exec_pkg::MSK_FILE) == exec_pkg::MAT_FILE) begin
      dec.op = exec_pkg::OP_FILE;
    end else if ((word & exec_pkg::MSK_INDM) == exec_pkg::MAT_INDM) begin
      dec.op  = exec_pkg::OP_IND;
      dec.sel = word[exec_pkg::SEL_MODE_B];
    end else if ((word & exec_pkg::MSK_INDR) == exec_pkg::MAT_INDR) begin
      dec.op  = exec_pkg::OP_IND;
      dec.sel = word[exec_pkg::SEL_REL_B];
      dec.rel = 1'b1;
    end
  end

  ptr_step u_step (
    .ptr_cur  (ptr_cur),
    .mode     (dec.mode),
    .rel      (dec.rel),
    .off      (dec.off),
    .eff_addr (eff_addr),
    .ptr_nxt  (ptr_nxt)
  );

  // Memory write source: store, indirect store or bus poke
  always_comb begin
    mem_we = 1'b0;
    mem_wa = maddr_q;
    mem_wd = acc_q;
    if (exec && dec.op == exec_pkg::OP_FILE) begin
      mem_we = 1'b1;
      if (dec.f == exec_pkg::WIN0_F) begin
        mem_wa = ptr0_q[AW-1:0];
      end else if (dec.f == exec_pkg::WIN1_F) begin
        mem_wa = ptr1_q[AW-1:0];
      end else begin
        mem_wa = dir_addr[AW-1:0];
      end
    end else if (exec && dec.op == exec_pkg::OP_IND) begin
      mem_we = 1'b1;
      mem_wa = eff_addr[AW-1:0];
    end else if (req_wr && avs_address == exec_pkg::REG_MDATA) begin
      mem_we = 1'b1;
      mem_wd = avs_writedata[exec_pkg::K8_W-1:0];
    end
  end

  byte_ram #(
    .AW (AW),
    .DW (exec_pkg::K8_W)
  ) u_ram (
    .clk_sys (clk_sys),
    .we      (mem_we),
    .waddr   (mem_wa),
    .wdata   (mem_wd),
    .raddr   (maddr_q),
    .rdata   (mem_rd)
  );

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (avs_address == exec_pkg::REG_ACC) begin
      rd_val = 32'(acc_q);
    end else if (avs_address == exec_pkg::REG_BANK) begin
      rd_val = 32'(bank_q);
    end else if (avs_address == exec_pkg::REG_PAGE) begin
      rd_val = 32'(page_q);
    end else if (avs_address == exec_pkg::REG_OPTION) begin
      rd_val = 32'(option_q);
    end else if (avs_address == exec_pkg::REG_PTR0) begin
      rd_val = 32'(ptr0_q);
    end else if (avs_address == exec_pkg::REG_PTR1) begin
      rd_val = 32'(ptr1_q);
    end else if (avs_address == exec_pkg::REG_PC) begin
      rd_val = 32'(pc_q);
    end else if (avs_address == exec_pkg::REG_PWR) begin
      rd_val = 32'(rif_q);
    end else if (avs_address == exec_pkg::REG_MADDR) begin
      rd_val = 32'(maddr_q);
    end else if (avs_address == exec_pkg::REG_MDATA) begin
      rd_val = 32'(mem_rd);
    end else if (avs_address == exec_pkg::REG_STATUS) begin
      rd_val = 32'(status_q);
    end
  end

  // Bus handshake: one wait cycle lets the RAM read settle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q            <= exec_pkg::ST_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      case (st_q)
        exec_pkg::ST_IDLE: begin
          if (avs_read || avs_write) begin
            st_q <= exec_pkg::ST_WAIT;
          end
        end
        exec_pkg::ST_WAIT: begin
          st_q            <= exec_pkg::ST_ACK;
          avs_waitrequest <= 1'b0;
          avs_readdata    <= avs_read ? rd_val : 32'h0000_0000;
        end
        default: begin
          st_q            <= exec_pkg::ST_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Working registers; soft reset reuses the power-on values
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      acc_q    <= '0;
      bank_q   <= '0;
      page_q   <= '0;
      option_q <= exec_pkg::OPTION_RST;
    end else if (soft_reset_req) begin
      acc_q    <= '0;
      bank_q   <= '0;
      page_q   <= '0;
      option_q <= exec_pkg::OPTION_RST;
    end else if (exec) begin
      case (dec.op)
        exec_pkg::OP_BANK: begin
          bank_q <= dec.lit[exec_pkg::K5_W-1:0];
        end
        exec_pkg::OP_PAGE: begin
          page_q <= dec.lit[exec_pkg::K7_W-1:0];
        end
        exec_pkg::OP_ACC: begin
          acc_q <= dec.lit;
        end
        exec_pkg::OP_OPTION: begin
          option_q <= acc_q;
        end
        default: begin
        end
      endcase
    end
  end

  // Pointers: indirect steps, or direct load by software
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ptr0_q <= '0;
      ptr1_q <= '0;
    end else if (soft_reset_req) begin
      ptr0_q <= '0;
      ptr1_q <= '0;
    end else if (exec && dec.op == exec_pkg::OP_IND) begin
      if (dec.sel) begin
        ptr1_q <= ptr_nxt;
      end else begin
        ptr0_q <= ptr_nxt;
      end
    end else if (req_wr && avs_address == exec_pkg::REG_PTR0) begin
      ptr0_q <= avs_writedata[exec_pkg::PW-1:0];
    end else if (req_wr && avs_address == exec_pkg::REG_PTR1) begin
      ptr1_q <= avs_writedata[exec_pkg::PW-1:0];
    end
  end

  // Program counter: one word per instruction, vector on reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pc_q <= '0;
    end else if (soft_reset_req) begin
      pc_q <= '0;
    end else if (exec && dec.op != exec_pkg::OP_SWRST) begin
      pc_q <= pc_q + 1'b1;
    end
  end

  // Flags: only software writes them; soft reset clears them, no other instruction does
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      status_q <= '0;
    end else if (soft_reset_req) begin
      status_q <= '0;
    end else if (req_wr && avs_address == exec_pkg::REG_STATUS) begin
      status_q <= avs_writedata[exec_pkg::ST_W-1:0];
    end
  end

  // Reset cause flag and the one-cycle reset request
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rif_q          <= exec_pkg::RIF_RST;
      soft_reset_req <= 1'b0;
    end else begin
      soft_reset_req <= exec && dec.op == exec_pkg::OP_SWRST;
      if (exec && dec.op == exec_pkg::OP_SWRST) begin
        rif_q <= 1'b0;
      end else if (req_wr && avs_address == exec_pkg::REG_PWR) begin
        rif_q <= avs_writedata[0];
      end
    end
  end

  // Memory peek address; cleared by reset and by soft reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      maddr_q <= '0;
    end else if (soft_reset_req) begin
      maddr_q <= '0;
    end else if (req_wr && avs_address == exec_pkg::REG_MADDR) begin
      maddr_q <= avs_writedata[AW-1:0];
    end
  end

  // Software reset: flag drops, then state returns to reset values
  sequence s_swrst_issue;
    exec && dec.op == exec_pkg::OP_SWRST;
  endsequence
  sequence s_swrst_done;
    soft_reset_req && !rif_q ##1 !soft_reset_req && pc_q == '0
      && acc_q == '0 && option_q == exec_pkg::OPTION_RST;
  endsequence

  AST_BANK_LIT: assert property (exec && dec.op == exec_pkg::OP_BANK
    |=> bank_q == $past(avs_writedata[exec_pkg::K5_W-1:0]))
    else $error("bank literal not loaded");
  AST_PAGE_LIT: assert property (exec && dec.op == exec_pkg::OP_PAGE
    |=> page_q == $past(avs_writedata[exec_pkg::K7_W-1:0]))
    else $error("page literal not loaded");
  AST_ACC_LIT: assert property (exec && dec.op == exec_pkg::OP_ACC
    |=> acc_q == $past(avs_writedata[exec_pkg::K8_W-1:0]))
    else $error("accumulator literal not loaded");
  AST_FILE_WR: assert property (exec && dec.op == exec_pkg::OP_FILE
    && dec.f > exec_pkg::WIN1_F |-> mem_we && mem_wd == acc_q
    && mem_wa == dir_addr[AW-1:0])
    else $error("direct store address or data wrong");
  AST_WINDOW: assert property (exec && dec.op == exec_pkg::OP_FILE
    && dec.f == exec_pkg::WIN1_F |-> mem_wa == ptr1_q[AW-1:0])
    else $error("window store not redirected");
  AST_PREDEC: assert property (exec && dec.op == exec_pkg::OP_IND
    && !dec.rel && dec.mode == exec_pkg::PM_PREDEC && !dec.sel
    |-> mem_wa == AW'(ptr0_q - 16'h0001)
    ##1 ptr0_q == $past(ptr0_q) - 16'h0001)
    else $error("predecrement address or pointer wrong");
  AST_POSTINC: assert property (exec && dec.op == exec_pkg::OP_IND
    && !dec.rel && dec.mode == exec_pkg::PM_POSTINC && dec.sel
    |-> mem_wa == ptr1_q[AW-1:0]
    ##1 ptr1_q == $past(ptr1_q) + 16'h0001)
    else $error("postincrement address or pointer wrong");
  AST_REL_KEEP: assert property (exec && dec.op == exec_pkg::OP_IND
    && dec.rel |=> $stable(ptr0_q) && $stable(ptr1_q))
    else $error("relative mode moved a pointer");
  AST_FLAGS: assert property (exec && dec.op != exec_pkg::OP_SWRST
    |=> $stable(status_q))
    else $error("instruction changed status flags");
  AST_OPTION: assert property (exec && dec.op == exec_pkg::OP_OPTION
    |=> option_q == $past(acc_q) && $stable(acc_q))
    else $error("option load wrong");
  AST_SWRST: assert property (s_swrst_issue |=> s_swrst_done)
    else $error("software reset did not complete");
  AST_SWRST_FLAGS: assert property (s_swrst_issue
    |=> $stable(status_q))
    else $error("flags moved before reset took hold");
  AST_NOOP: assert property (exec && dec.op == exec_pkg::OP_NOOP
    |=> $stable(acc_q) && $stable(ptr0_q) && $stable(ptr1_q)
    && pc_q == $past(pc_q) + 1'b1)
    else $error("no_operation changed state");
  AST_ACK_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held more than one cycle");

endmodule
`default_nettype wire

// file: design/exec_pkg.sv
// Constants, types and register map of the literal and indirect move
// executor. Assumes every user names items as exec_pkg::name.
package exec_pkg;

  // Widths of words and fields
  localparam int IW     = 14;  // Instruction word
  localparam int PW     = 16;  // File select pointer
  localparam int PC_W   = 15;  // Program counter
  localparam int K5_W   = 5;   // Bank literal
  localparam int K7_W   = 7;   // Page literal and file address
  localparam int K8_W   = 8;   // Accumulator literal and data
  localparam int OFF_W  = 6;   // Signed relative offset
  localparam int PM_W   = 2;   // Pointer mode code
  localparam int ST_W   = 3;   // Status flags
  localparam int MEM_AW = 12;  // Default data memory address width

  // Pointer select bit positions in the two indirect forms
  localparam int SEL_MODE_B = 2;
  localparam int SEL_REL_B  = 6;

  // Opcode masks and matches, checked in this order
  localparam logic [IW-1:0] ENC_NOOP   = 14'h0000;
  localparam logic [IW-1:0] ENC_SWRST  = 14'h0001;
  localparam logic [IW-1:0] ENC_OPTION = 14'h0062;
  localparam logic [IW-1:0] MSK_BANK   = 14'h3fe0;
  localparam logic [IW-1:0] MAT_BANK   = 14'h0020;
  localparam logic [IW-1:0] MSK_PAGE   = 14'h3f80;
  localparam logic [IW-1:0] MAT_PAGE   = 14'h3180;
  localparam logic [IW-1:0] MSK_ACC    = 14'h3c00;
  localparam logic [IW-1:0] MAT_ACC    = 14'h3000;
  localparam logic [IW-1:0] MSK_FILE   = 14'h3f80;
  localparam logic [IW-1:0] MAT_FILE   = 14'h0080;
  localparam logic [IW-1:0] MSK_INDM   = 14'h3ff8;
  localparam logic [IW-1:0] MAT_INDM   = 14'h0018;
  localparam logic [IW-1:0] MSK_INDR   = 14'h3f80;
  localparam logic [IW-1:0] MAT_INDR   = 14'h3f80;

  // File addresses that act as indirect windows
  localparam logic [K7_W-1:0] WIN0_F = 7'h00;
  localparam logic [K7_W-1:0] WIN1_F = 7'h01;

  // Register byte offsets on the bus
  localparam logic [5:0] REG_INSTR  = 6'h00;
  localparam logic [5:0] REG_ACC    = 6'h04;
  localparam logic [5:0] REG_BANK   = 6'h08;
  localparam logic [5:0] REG_PAGE   = 6'h0c;
  localparam logic [5:0] REG_OPTION = 6'h10;
  localparam logic [5:0] REG_PTR0   = 6'h14;
  localparam logic [5:0] REG_PTR1   = 6'h18;
  localparam logic [5:0] REG_PC     = 6'h1c;
  localparam logic [5:0] REG_PWR    = 6'h20;
  localparam logic [5:0] REG_MADDR  = 6'h24;
  localparam logic [5:0] REG_MDATA  = 6'h28;
  localparam logic [5:0] REG_STATUS = 6'h2c;

  // Reset values
  localparam logic [K8_W-1:0] OPTION_RST = 8'hff;
  localparam logic            RIF_RST    = 1'b1;

  // Decoded operations
  typedef enum logic [3:0] {
    OP_NOOP   = 4'h0,
    OP_BANK   = 4'h1,
    OP_PAGE   = 4'h2,
    OP_ACC    = 4'h3,
    OP_FILE   = 4'h4,
    OP_IND    = 4'h5,
    OP_OPTION = 4'h6,
    OP_SWRST  = 4'h7,
    OP_UNDEF  = 4'h8
  } op_t;

  // Pointer mode codes
  typedef enum logic [PM_W-1:0] {
    PM_PREINC  = 2'b00,
    PM_PREDEC  = 2'b01,
    PM_POSTINC = 2'b10,
    PM_POSTDEC = 2'b11
  } pmode_t;

  // Bus slave states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_ACK  = 2'b10
  } bus_st_t;

  // One decoded instruction
  typedef struct packed {
    op_t              op;
    logic [K8_W-1:0]  lit;
    logic [K7_W-1:0]  f;
    logic             sel;
    pmode_t           mode;
    logic             rel;
    logic [OFF_W-1:0] off;
  } dec_t;

endpackage

// file: design/byte_ram.sv
// Single write port data memory with a registered read port.
// Assumes one clock; contents are undefined after reset.
`timescale 1ns/1ps
`default_nettype none
module byte_ram #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input  wire logic          clk_sys,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output var  logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [2**AW];  // Storage, no reset to keep it a RAM

  // Write port
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read, one cycle behind the address
  always_ff @(posedge clk_sys) begin
    rdata <= mem[raddr];
  end

endmodule
`default_nettype wire

// file: design/ptr_step.sv
// Effective address and next value of one file select pointer.
// Assumes a combinational caller that decides whether to commit.
`timescale 1ns/1ps
`default_nettype none
module ptr_step (
  input  wire logic [exec_pkg::PW-1:0]    ptr_cur,
  input  wire exec_pkg::pmode_t           mode,
  input  wire logic                       rel,
  input  wire logic [exec_pkg::OFF_W-1:0] off,
  output logic [exec_pkg::PW-1:0]         eff_addr,
  output logic [exec_pkg::PW-1:0]         ptr_nxt
);

  logic [exec_pkg::PW-1:0] p_inc;  // Wraps at the top of the range
  logic [exec_pkg::PW-1:0] p_dec;  // Wraps at the bottom
  logic [exec_pkg::PW-1:0] p_rel;  // Pointer plus signed offset

  assign p_inc = ptr_cur + 16'h0001;
  assign p_dec = ptr_cur - 16'h0001;
  assign p_rel = ptr_cur + {{(exec_pkg::PW-exec_pkg::OFF_W){off[
    exec_pkg::OFF_W-1]}}, off};

  // Mode decode; relative form never moves the pointer
  always_comb begin
    eff_addr = ptr_cur;
    ptr_nxt  = ptr_cur;
    if (rel) begin
      eff_addr = p_rel;
    end else begin
      case (mode)
        exec_pkg::PM_PREINC: begin
          eff_addr = p_inc;
          ptr_nxt  = p_inc;
        end
        exec_pkg::PM_PREDEC: begin
          eff_addr = p_dec;
          ptr_nxt  = p_dec;
        end
        exec_pkg::PM_POSTINC: begin
          ptr_nxt = p_inc;
        end
        default: begin
          ptr_nxt = p_dec;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// file: dv/lit_move_exec_bench.sv
// Self-checking bench for the literal and indirect move executor.
// Assumes the register map and bus answer of the executor's note.
`timescale 1ns/1ps
`default_nettype none
module lit_move_exec_bench;
  logic        clk_sys;          // 25 MHz clock
  logic        resetn;           // Active low reset
  logic [5:0]  avs_address;      // Register offset
  logic        avs_read;         // Read strobe
  logic        avs_write;        // Write strobe
  logic [31:0] avs_writedata;    // Write data
  logic [31:0] avs_readdata;     // Read data
  logic        avs_waitrequest;  // Stall
  logic        soft_reset_req;   // Reset pulse
  int          errors;           // Mismatches
  int          checks_done;      // Comparisons
  int          seed;             // Random seed
  int          pulses;           // Reset pulses seen
  int          i;                // Loop index
  logic [31:0] k;                // Random draw
  logic [31:0] q;                // Last read data
  logic [7:0]  acc;              // Expected accumulator
  logic [14:0] pc;               // Expected program counter
  logic [15:0] ptr [2];          // Expected pointers
  logic [15:0] e;                // Expected address
  logic [6:0]  f;                // File address
  logic        n;                // Pointer index
  logic [1:0]  m;                // Pointer mode
  lit_move_exec u_dut (
    .clk_sys         (clk_sys),
    .resetn          (resetn),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .soft_reset_req  (soft_reset_req)
  );
  // Free running clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Count reset pulses; a stuck pulse shows as more than one
  always @(posedge clk_sys) begin
    if (soft_reset_req === 1'b1) pulses++;
  end
  // Compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One bus transfer; called at an edge, returns one edge after release
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int c;
    c = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do begin
      @(posedge clk_sys);
      c++;
    end while (avs_waitrequest !== 1'b0 && c < 40);
    // A slave that never answers counts as a mismatch
    if (c >= 40) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h1, 32'h0);
    end
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  // Execute one instruction word; each, the software reset included, advances the expected PC by one
  task automatic ex(input logic [13:0] w);
    bus(1'b1, exec_pkg::REG_INSTR, {18'h0, w});
    pc = pc + 15'h1;
  endtask
  // Peek one memory byte
  task automatic mem(input logic [11:0] a, input logic [7:0] x);
    bus(1'b1, exec_pkg::REG_MADDR, {20'h0, a});
    rd(exec_pkg::REG_MDATA, {24'h0, x});
  endtask
  // Pointer after one step, wrapping at both ends
  function automatic logic [15:0] step(input logic [15:0] p, input logic [1:0] md);
    return md[0] ? p - 16'h1 : p + 16'h1;
  endfunction
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Watchdog, about ten times the expected run
  initial begin
    #(40 * 30000);
    errors++;
    complete_run;
  end
  // Main sequence
  initial begin
    seed = 88;
    errors = 0;
    checks_done = 0;
    pulses = 0;
    resetn = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    acc = 8'h00;
    pc = 15'h0;
    ptr[0] = 16'h0;
    ptr[1] = 16'h0;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(exec_pkg::REG_OPTION, 32'hff);
    rd(exec_pkg::REG_PWR, 32'h1);
    rd(exec_pkg::REG_PTR0, 32'h0);
    rd(6'h3c, 32'h0);
    bus(1'b1, exec_pkg::REG_STATUS, 32'h5);
    for (i = 0; i < 24; i++) begin
      k = $random(seed);
      acc = k[7:0];
      ex(14'h3000 | {6'h0, acc});
      rd(exec_pkg::REG_ACC, {24'h0, acc});
      ex(14'h0020 | {9'h0, k[12:8]});
      rd(exec_pkg::REG_BANK, {27'h0, k[12:8]});
      ex(14'h3180 | {7'h0, k[22:16]});
      rd(exec_pkg::REG_PAGE, {25'h0, k[22:16]});
      ex(exec_pkg::ENC_OPTION);
      rd(exec_pkg::REG_OPTION, {24'h0, acc});
      f = (k[30:24] < 7'h2) ? 7'h7f : k[30:24];
      ex(14'h0080 | {7'h0, f});
      mem({k[12:8], f}, acc);
      // Boundary pointers first, to make the wrap show
      n = k[31];
      m = i[1:0];
      ptr[n] = (i < 4) ? 16'hffff : (i < 8) ? 16'h0 : k[23:8];
      bus(1'b1, n ? exec_pkg::REG_PTR1 : exec_pkg::REG_PTR0, {16'h0, ptr[n]});
      e = m[1] ? ptr[n] : step(ptr[n], m);
      ptr[n] = step(ptr[n], m);
      ex(14'h0018 | {11'h0, n, m});
      rd(n ? exec_pkg::REG_PTR1 : exec_pkg::REG_PTR0, {16'h0, ptr[n]});
      mem(e[11:0], acc);
      acc = ~acc;
      ex(14'h3000 | {6'h0, acc});
      e = ptr[n] + {{10{k[5]}}, k[5:0]};
      ex(14'h3f80 | {7'h0, n, k[5:0]});
      rd(n ? exec_pkg::REG_PTR1 : exec_pkg::REG_PTR0, {16'h0, ptr[n]});
      mem(e[11:0], acc);
      ex(14'h0080 | {13'h0, n});
      mem(ptr[n][11:0], acc);
      ex(exec_pkg::ENC_NOOP);
      rd(exec_pkg::REG_ACC, {24'h0, acc});
      rd(exec_pkg::REG_PC, {17'h0, pc});
      rd(exec_pkg::REG_STATUS, 32'h5);
    end
    ex(exec_pkg::ENC_SWRST);
    rd(exec_pkg::REG_PWR, 32'h0);
    rd(exec_pkg::REG_PC, 32'h0);
    rd(exec_pkg::REG_ACC, 32'h0);
    rd(exec_pkg::REG_OPTION, 32'hff);
    chk(pulses, 32'h1);
    complete_run;
  end
endmodule
`default_nettype wire
